// ==== verilog/ext_irq_pkg.sv ====
/*
 * Constants for the external interrupt pending flag block.
 * Assumes a single core clock and an 8-bit register port.
 */
package ext_irq_pkg;
    localparam int          SRC_COUNT        = 8;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 8;
    localparam logic [7:0]  PENDING_OFFSET   = 8'hF1;
    localparam logic [7:0]  PENDING_RESET    = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET    = 8'hF2;
    localparam logic [7:0]  MASK_OFFSET      = 8'hF3;
    localparam logic [7:0]  STATUS_RESET     = 8'h00;
    localparam logic [7:0]  MASK_RESET       = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ    = 8'h00;
    localparam int          BIT_SRC0         = 0;
    localparam int          BIT_SRC4         = 4;
    localparam int          BIT_SRC5         = 5;
    localparam int          BIT_SRC7         = 7;
endpackage

// ==== verilog/ext_irq_if.sv ====
/*
 * Register access bundle between the top module and the flag core.
 * Assumes one write strobe per cycle.
 */
`timescale 1ns/1ps
interface ext_irq_if;
    logic [7:0] wr_data;
    logic       wr_pending;
    logic [7:0] pending;
    modport top  (output wr_data, output wr_pending, input pending);
    modport core (input wr_data, input wr_pending, output pending);
endinterface

// ==== verilog/ext_irq_flag_core.sv ====
/*
 * Eight pending flags: set by source requests, cleared by writing zero.
 * Assumes request pulses are synchronous to clk_in.
 */
`timescale 1ns/1ps
module ext_irq_flag_core
    import ext_irq_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 clk_en_in,
    // Sources and register access
    input  wire logic [SRC_COUNT-1:0] req_in,
    ext_irq_if.core                   bus
);
    logic [SRC_COUNT-1:0] pending_r;

    assign bus.pending = pending_r;

    genvar g;
    generate
        for (g = 0; g < SRC_COUNT; g++) begin : g_flag
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    pending_r[g] <= PENDING_RESET[g];
                end else if (clk_en_in) begin
                    // Set wins over a simultaneous clear; writing one keeps the flag
                    if (req_in[g]) begin
                        pending_r[g] <= 1'b1;
                    end else if (bus.wr_pending && !bus.wr_data[g]) begin
                        pending_r[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
endmodule

// ==== verilog/ext_irq_pending_flags.sv ====
/*
 * Top of the external interrupt pending flags, with register port,
 * sticky event status, mask and one interrupt output.
 * Assumes the master keeps strobes one cycle long and never together.
 */
`timescale 1ns/1ps
// How it works
// - Source 7 request from port3_pin7 sets pending bit 7.
// - Source 5 request from port3_pin5 sets pending bit 5.
// - Source 4 request from port3_pin4 sets pending bit 4.
// - Source 0 request from port2_pin0 sets pending bit 0.
// - Reading returns one for outstanding requests, zero otherwise.
// - Writing zero to a pending bit clears that flag.
module ext_irq_pending_flags
    import ext_irq_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    input  wire logic                    clk_en_in,
    // External request pulses
    input  wire logic                    port3_pin7_in,
    input  wire logic                    ext_irq_src6_in,
    input  wire logic                    port3_pin5_in,
    input  wire logic                    port3_pin4_in,
    input  wire logic                    ext_irq_src3_in,
    input  wire logic                    ext_irq_src2_in,
    input  wire logic                    ext_irq_src1_in,
    input  wire logic                    port2_pin0_in,
    // Register port
    input  wire logic [ext_irq_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [ext_irq_pkg::DATA_W-1:0] wr_data_in,
    input  wire logic                    wr_in,
    input  wire logic                    rd_in,
    output logic [ext_irq_pkg::DATA_W-1:0]      rd_data_out,
    // Interrupt
    output logic                         irq_out
);
    import ext_irq_pkg::*;

    ext_irq_if bus_if ();

    logic [SRC_COUNT-1:0] req;
    logic [SRC_COUNT-1:0] status_r;
    logic [SRC_COUNT-1:0] mask_r;
    logic [DATA_W-1:0]    rd_data_r;
    logic                 irq_r;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    always_comb begin
        req          = '0;
        req[BIT_SRC7] = port3_pin7_in;
        req[6]       = ext_irq_src6_in;
        req[BIT_SRC5] = port3_pin5_in;
        req[BIT_SRC4] = port3_pin4_in;
        req[3]       = ext_irq_src3_in;
        req[2]       = ext_irq_src2_in;
        req[1]       = ext_irq_src1_in;
        req[BIT_SRC0] = port2_pin0_in;
    end

    assign bus_if.wr_data    = wr_data_in;
    assign bus_if.wr_pending = wr_in && hit(addr_in, PENDING_OFFSET);

    ext_irq_flag_core u_core (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .clk_en_in (clk_en_in),
        .req_in    (req),
        .bus       (bus_if.core)
    );

    // Sticky event status, write one to clear, set wins
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_r <= STATUS_RESET;
        end else if (clk_en_in) begin
            if (wr_in && hit(addr_in, STATUS_OFFSET)) begin
                status_r <= (status_r & ~wr_data_in) | req;
            end else begin
                status_r <= status_r | req;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask_r <= MASK_RESET;
        end else if (clk_en_in && wr_in && hit(addr_in, MASK_OFFSET)) begin
            mask_r <= wr_data_in;
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_r <= UNMAPPED_READ;
        end else if (clk_en_in) begin
            if (!rd_in) begin
                rd_data_r <= UNMAPPED_READ;
            end else if (hit(addr_in, PENDING_OFFSET)) begin
                rd_data_r <= bus_if.pending;
            end else if (hit(addr_in, STATUS_OFFSET)) begin
                rd_data_r <= status_r;
            end else if (hit(addr_in, MASK_OFFSET)) begin
                rd_data_r <= mask_r;
            end else begin
                rd_data_r <= UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_r <= 1'b0;
        end else if (clk_en_in) begin
            irq_r <= |(status_r & mask_r);
        end
    end

    assign rd_data_out = rd_data_r;
    assign irq_out     = irq_r;
endmodule

// ==== test/ext_irq_pending_flags_assertions.sv ====
/* Checker for the pending flag block.
   Assumes a master with one-cycle strobes; frozen cycles match nothing. */
`timescale 1ns/1ps
module ext_irq_pending_flags_checker
    import ext_irq_pkg::*;
(
    input wire logic       clk_in, rst_n_in, clk_en_in, wr_in, rd_in,
    input wire logic       port3_pin7_in, port3_pin5_in, port3_pin4_in, port2_pin0_in, ext_irq_src1_in,
    input wire logic [7:0] addr_in, wr_data_in, rd_data_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence rd_s; clk_en_in && rd_in && addr_in == PENDING_OFFSET; endsequence
    sequence wr_s; clk_en_in && wr_in && addr_in == PENDING_OFFSET; endsequence
    property set_p(logic src, int b);
        (clk_en_in && src) ##1 !wr_in ##1 rd_s |=> rd_data_out[b];
    endproperty
    src7_set_a: assert property (set_p(port3_pin7_in, 7)) else $error("bit 7 not set");
    src5_set_a: assert property (set_p(port3_pin5_in, 5)) else $error("bit 5 not set");
    src4_set_a: assert property (set_p(port3_pin4_in, 4)) else $error("bit 4 not set");
    src0_set_a: assert property (set_p(port2_pin0_in, 0)) else $error("bit 0 not set");
    idle_zero_a: assert property (clk_en_in && !rd_in |=> rd_data_out == 8'h00)
        else $error("data not zero");
    clear_zero_a: assert property ((wr_s and (!wr_data_in[0] && !port2_pin0_in)) ##1
        !port2_pin0_in ##1 rd_s |=> !rd_data_out[0]) else $error("bit 0 not cleared");
    write_one_a: assert property ((clk_en_in && ext_irq_src1_in) ##1 !wr_in ##1 rd_s ##1 !wr_in
        ##1 (wr_s and wr_data_in[1]) ##1 !wr_in ##1 rd_s |=> rd_data_out[1]) else $error("bit 1 lost");
endmodule
bind ext_irq_pending_flags ext_irq_pending_flags_checker ext_irq_pending_flags_checker_i (.clk_in, .rst_n_in,
    .clk_en_in, .wr_in, .rd_in, .port3_pin7_in, .port3_pin5_in, .port3_pin4_in, .port2_pin0_in,
    .ext_irq_src1_in, .addr_in, .wr_data_in, .rd_data_out);

// ==== test/ext_irq_pin_model.sv ====
/* Model of the eight external request pins.
   Assumes the bench calls fire from one thread. */
`timescale 1ns/1ps
module ext_irq_pin_model (
    input  wire logic       clk_in,
    output logic      [7:0] req_out
);
    initial req_out = 8'h00;
    // One-cycle request, pins idle low
    task automatic fire(input int b);
        @(posedge clk_in);
        req_out[b] <= 1'b1;
        @(posedge clk_in);
        req_out[b] <= 1'b0;
    endtask
endmodule

// ==== test/ext_irq_pending_flags_test.sv ====
/* Bench for the pending flag block.
   Assumes the pin model and the bound checker. */
`timescale 1ns/1ps
module ext_irq_pending_flags_test;
    import ext_irq_pkg::*;
    logic       clk_in, rst_n_in, clk_en_in, wr_in, rd_in, irq_out;
    logic [7:0] addr_in, wr_data_in, rd_data_out, req;
    int         failures, checked;
    ext_irq_pin_model ext_irq_pin_model_i (.clk_in(clk_in), .req_out(req));
    ext_irq_pending_flags ext_irq_pending_flags_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
        .port3_pin7_in(req[7]), .ext_irq_src6_in(req[6]), .port3_pin5_in(req[5]), .port3_pin4_in(req[4]),
        .ext_irq_src3_in(req[3]), .ext_irq_src2_in(req[2]), .ext_irq_src1_in(req[1]), .port2_pin0_in(req[0]),
        .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
        .rd_data_out(rd_data_out), .irq_out(irq_out));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk("read data", e, rd_data_out);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        rst_n_in = 1'b0;
        clk_en_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wr_data_in = 8'h00;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(PENDING_OFFSET, PENDING_RESET);
        rd(8'h10, UNMAPPED_READ);
        $display("test done: reset and unmapped");
        for (int i = 0; i < 8; i++) begin
            ext_irq_pin_model_i.fire(i);
            rd(PENDING_OFFSET, 8'(8'h01 << i));
            wr(PENDING_OFFSET, 8'hFF);
            rd(PENDING_OFFSET, 8'(8'h01 << i));
            wr(PENDING_OFFSET, 8'h00);
            rd(PENDING_OFFSET, 8'h00);
        end
        $display("test done: set and clear per source");
        // Frozen cycles neither set nor clear a flag
        ext_irq_pin_model_i.fire(3);
        @(posedge clk_in);
        clk_en_in <= 1'b0;
        ext_irq_pin_model_i.fire(2);
        wr(PENDING_OFFSET, 8'h00);
        clk_en_in <= 1'b1;
        rd(PENDING_OFFSET, 8'h08);
        wr(PENDING_OFFSET, 8'h00);
        rd(PENDING_OFFSET, 8'h00);
        $display("test done: clock enable freeze");
        wr(STATUS_OFFSET, 8'hFF);
        wr(MASK_OFFSET, 8'h01);
        ext_irq_pin_model_i.fire(1);
        rd(STATUS_OFFSET, 8'h02);
        chk("irq", 8'h00, {7'h00, irq_out});
        ext_irq_pin_model_i.fire(0);
        rd(STATUS_OFFSET, 8'h03);
        chk("irq", 8'h01, {7'h00, irq_out});
        wr(STATUS_OFFSET, 8'h01);
        rd(MASK_OFFSET, 8'h01);
        chk("irq", 8'h00, {7'h00, irq_out});
        $display("test done: interrupt");
        // Reset in mid-run with flags, status and mask set
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(PENDING_OFFSET, PENDING_RESET);
        rd(STATUS_OFFSET, STATUS_RESET);
        rd(MASK_OFFSET, MASK_RESET);
        chk("irq", 8'h00, {7'h00, irq_out});
        $display("test done: mid-run reset");
        close_out;
    end
endmodule
